// ===== common/dmm_pkg.sv
// dual mac/mas datapath: shared constants
// assumes a 32-bit classic wishbone slave port and a 16-bit operand memory
package dmm_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DMM_ACC_W  = 40;
  localparam int DMM_WORD_W = 16;
  localparam int DMM_ADR_W  = 16;
  localparam int DMM_NACC   = 4;
  localparam int DMM_RPT_W  = 8;
  localparam int DMM_WB_AW  = 8;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] DMM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DMM_OFS_STATUS = 8'h04;
  localparam logic [7:0] DMM_OFS_CPTR   = 8'h08;
  localparam logic [7:0] DMM_OFS_APTR3  = 8'h0C;
  localparam logic [7:0] DMM_OFS_RPT    = 8'h10;
  localparam logic [2:0] DMM_ACC_REGION = 3'h1;   // 0x20..0x3C, acc i at 0x20+8*i
  localparam int         DMM_ACC_REG_HI = 7;
  localparam int         DMM_ACC_REG_LO = 5;
  localparam int         DMM_ACC_IDX_HI = 4;
  localparam int         DMM_ACC_IDX_LO = 3;
  localparam int         DMM_ACC_HALF   = 2;

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int DMM_CTRL_FRAC  = 0;
  localparam int DMM_CTRL_MUL_SAT_MODE  = 1;
  localparam int DMM_CTRL_RDM   = 2;
  localparam int DMM_CTRL_WIDE  = 3;
  localparam int DMM_CTRL_SAT   = 4;
  localparam int DMM_CTRL_W     = 5;
  localparam logic [4:0] DMM_CTRL_RST = 5'h00;
  localparam int DMM_ST_BAD     = 8;
  localparam int DMM_ST_BUSY    = 9;
  localparam logic [15:0] DMM_PTR_RST  = 16'h0000;
  localparam logic [15:0] DMM_PTR_STEP = 16'h0002;
  localparam logic [7:0]  DMM_RPT_RST  = 8'h00;

  // ****************************************
  // instruction word fields
  // ****************************************
  localparam logic [7:0] DMM_OPC_FIRST  = 8'hFD;
  localparam logic [3:0] DMM_NIB_SHIFT  = 4'h6;
  localparam logic [3:0] DMM_NIB_PLAIN  = 4'h4;   // unshifted form
  localparam logic [1:0] DMM_FIX_BITS   = 2'h1;
  localparam int DMM_F_OPC_HI = 31;
  localparam int DMM_F_OPC_LO = 24;
  localparam int DMM_F_XM_HI  = 17;
  localparam int DMM_F_XM_LO  = 16;
  localparam int DMM_F_NIB_HI = 15;
  localparam int DMM_F_NIB_LO = 12;
  localparam int DMM_F_FIX_HI = 11;
  localparam int DMM_F_FIX_LO = 10;
  localparam int DMM_F_CM_HI  = 9;
  localparam int DMM_F_CM_LO  = 8;
  localparam int DMM_F_SUB_HI = 7;
  localparam int DMM_F_SUB_LO = 6;
  localparam int DMM_F_ADD_HI = 5;
  localparam int DMM_F_ADD_LO = 4;
  localparam int DMM_F_UNS_D  = 3;
  localparam int DMM_F_UNS_C  = 2;
  localparam int DMM_F_WIDE   = 1;
  localparam int DMM_F_RND    = 0;

  // ****************************************
  // arithmetic constants
  // ****************************************
  localparam logic [16:0] DMM_MUL_SAT_MODE_MIN  = 17'h18000;
  localparam logic [33:0] DMM_MUL_SAT_MODE_SAT  = 34'h07FFFFFFF;
  localparam logic [41:0] DMM_ROUND_ADD = 42'h00000008000;
  localparam logic [15:0] DMM_HALF16    = 16'h8000;
  localparam logic [39:0] DMM_MAX32     = 40'h007FFFFFFF;
  localparam logic [39:0] DMM_MIN32     = 40'hFF80000000;
  localparam logic [39:0] DMM_MAX40     = 40'h7FFFFFFFFF;
  localparam logic [39:0] DMM_MIN40     = 40'h8000000000;

  typedef enum logic [1:0] {
    DMM_PM_KEEP  = 2'b00,
    DMM_PM_INC   = 2'b01,
    DMM_PM_DEC   = 2'b10,
    DMM_PM_KEEP2 = 2'b11
  } dmm_ptr_mode_type;

  typedef enum logic [0:0] {
    DMM_ST_IDLE = 1'b0,
    DMM_ST_RPT  = 1'b1
  } dmm_state_type;

endpackage : dmm_pkg

// ===== design/dmm_core.sv
// dual multiply-accumulate / multiply-subtract datapath
// assumes operand memory answers one cycle after the read strobe,
// all partners on clk_i, a classic wishbone master for registers
//
// Behaviour
// - upper add and lower subtract complete in one cycle.
// - long data high half on long_read_bus_hi, sign extended to 17.
// - long data low half on data_read_bus, sign extended to 17.
// - coefficient high half on coef_bus_hi, sign extended to 17.
// - coefficient low half on coef_bus_lo, sign extended to 17.
// - low half address is effective address with bit 0 flipped.
// - unsigned option zero extends that operand to 17 bits instead.
// - fractional mode shifts each product left by one bit.
// - mul_sat_mode governs product overflow handling.
// - upper product sign extended to 40 bits, added into add_acc.
// - shifted form pre-shifts add_acc right 16, filling with bit 39.
// - lower product sign extended to 40 bits, subtracted from sub_acc.
// - round option rounds both results, method from round_mode_sel.
// - overflow width from wide_ovf_mode; sets destination flag.
// - on overflow the destination saturates when acc_sat_mode is set.
// - wide option forces wide_ovf_mode for one instruction only.
// - coefficient fetched over coef_addr_bus, coef_bus_lo and coef_bus_hi.
// - accepted inside a single-instruction repeat loop.
// - coefficient pointer post-increment with high/low advances by 2.
// - aux pointer three post-decrement with high/low drops by 2.
// - shifted form decodes first byte 11111101, third byte nibble 0110.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps

module dmm_core
  import dmm_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [DMM_WB_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // instruction issue
  input  wire logic                  inst_valid_i,
  input  wire logic [31:0]           inst_word_i,
  output logic                       inst_ready_o,
  // operand memory
  output logic                       rd_stb_o,
  output logic      [DMM_ADR_W-1:0]  data_addr_hi_o,
  output logic      [DMM_ADR_W-1:0]  data_addr_lo_o,
  output logic      [DMM_ADR_W-1:0]  coef_addr_bus_hi_o,
  output logic      [DMM_ADR_W-1:0]  coef_addr_bus_lo_o,
  input  wire logic [DMM_WORD_W-1:0] long_read_bus_hi_i,
  input  wire logic [DMM_WORD_W-1:0] data_read_bus_i,
  input  wire logic [DMM_WORD_W-1:0] coef_bus_hi_i,
  input  wire logic [DMM_WORD_W-1:0] coef_bus_lo_i,
  // status
  output logic                       busy_o,
  output logic                       done_o,
  output logic      [DMM_NACC-1:0]   acc_ovf_flag_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [16:0] ext17(input logic [15:0] v, input logic uns);
    ext17 = uns ? {1'b0, v} : {v[15], v};
  endfunction : ext17

  function automatic logic [39:0] mul_lane(input logic [16:0] a, input logic [16:0] b,
                                           input logic frac, input logic mul_sat_mode);
    logic signed [33:0] p;
    p = $signed(a) * $signed(b);
    if (frac) begin
      p = p <<< 1;
    end
    if (mul_sat_mode && frac && a == DMM_MUL_SAT_MODE_MIN && b == DMM_MUL_SAT_MODE_MIN) begin
      p = DMM_MUL_SAT_MODE_SAT;
    end
    mul_lane = {{6{p[33]}}, p};
  endfunction : mul_lane

  // returns {overflow, result}
  function automatic logic [40:0] acc_lane(input logic [39:0] src, input logic [39:0] prod,
                                           input logic sub, input logic rnd, input logic round_mode_sel,
                                           input logic wide, input logic sat);
    logic [41:0] s;
    logic        tie;
    logic        ovf;
    logic [39:0] r;
    s   = sub ? ({{2{src[39]}}, src} - {{2{prod[39]}}, prod})
              : ({{2{src[39]}}, src} + {{2{prod[39]}}, prod});
    tie = (s[15:0] == DMM_HALF16);
    if (rnd) begin
      s = s + DMM_ROUND_ADD;
      if (round_mode_sel && tie) begin
        s[16] = 1'b0;  // round half to even
      end
      s[15:0] = 16'h0000;
    end
    ovf = wide ? (s[41:39] != {3{s[41]}}) : (s[41:31] != {11{s[41]}});
    r   = s[39:0];
    if (ovf && sat) begin
      r = s[41] ? (wide ? DMM_MIN40 : DMM_MIN32) : (wide ? DMM_MAX40 : DMM_MAX32);
    end
    acc_lane = {ovf, r};
  endfunction : acc_lane

  function automatic logic [15:0] ptr_next(input logic [15:0] p, input logic [1:0] mode);
    case (mode)
      DMM_PM_INC: ptr_next = p + DMM_PTR_STEP;
      DMM_PM_DEC: ptr_next = p - DMM_PTR_STEP;
      default:    ptr_next = p;
    endcase
  endfunction : ptr_next

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  function automatic logic decode_ok(input logic [31:0] w);
    decode_ok = (w[DMM_F_OPC_HI:DMM_F_OPC_LO] == DMM_OPC_FIRST) &&
                (w[DMM_F_FIX_HI:DMM_F_FIX_LO] == DMM_FIX_BITS) &&
                (w[DMM_F_NIB_HI:DMM_F_NIB_LO] == DMM_NIB_SHIFT ||
                 w[DMM_F_NIB_HI:DMM_F_NIB_LO] == DMM_NIB_PLAIN);
  endfunction : decode_ok

  // ****************************************
  // declarations
  // ****************************************
  logic [DMM_CTRL_W-1:0] ctrl_q;
  logic [DMM_NACC-1:0]   ovf_q;
  logic                  bad_q;
  logic [15:0]           cptr_q;
  logic [15:0]           aptr3_q;
  logic [DMM_RPT_W-1:0]  rpt_q;
  logic [DMM_RPT_W-1:0]  rpt_left_q;
  logic [39:0]           acc_q [DMM_NACC];
  dmm_state_type         state_q;
  logic [31:0]           held_q;
  logic                  s1_valid_q;
  logic [31:0]           s1_word_q;
  logic                  s2_valid_q;
  logic [31:0]           s2_word_q;
  logic                  done_q;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic [DMM_ADR_W-1:0]  xa_q;
  logic [DMM_ADR_W-1:0]  ca_q;

  logic        wb_req;
  logic        wb_wr;
  logic        acc_sel;
  logic [1:0]  acc_idx;
  logic        accept;
  logic        issue;
  logic [31:0] issue_word;
  logic [31:0] rd_d;

  logic [1:0]  sub_idx;
  logic [1:0]  add_idx;
  logic        wide_eff;
  logic [39:0] add_src;
  logic [39:0] prod_hi;
  logic [39:0] prod_lo;
  logic [40:0] add_res;
  logic [40:0] sub_res;
  logic [DMM_NACC-1:0] ovf_set;
  logic [DMM_NACC-1:0] ovf_clr;

  // ****************************************
  // wishbone decode
  // ****************************************
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr   = wb_req && wb_we_i;
  assign acc_sel = (wb_adr_i[DMM_ACC_REG_HI:DMM_ACC_REG_LO] == DMM_ACC_REGION);
  assign acc_idx = wb_adr_i[DMM_ACC_IDX_HI:DMM_ACC_IDX_LO];

  // unmapped addresses read zero, ignore writes, still ack
  always_comb begin
    rd_d = 32'h00000000;
    if (acc_sel) begin
      rd_d = wb_adr_i[DMM_ACC_HALF] ? {24'h000000, acc_q[acc_idx][39:32]} : acc_q[acc_idx][31:0];
    end else begin
      case (wb_adr_i)
        DMM_OFS_CTRL:   rd_d[DMM_CTRL_W-1:0] = ctrl_q;
        DMM_OFS_STATUS: rd_d = {22'h000000, busy_o, bad_q, 4'h0, ovf_q};
        DMM_OFS_CPTR:   rd_d[15:0] = cptr_q;
        DMM_OFS_APTR3:  rd_d[15:0] = aptr3_q;
        DMM_OFS_RPT:    rd_d[DMM_RPT_W-1:0] = rpt_q;
        default:        rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= rd_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= DMM_CTRL_RST;
      rpt_q  <= DMM_RPT_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == DMM_OFS_CTRL) begin
        ctrl_q <= DMM_CTRL_W'(merge({27'h0000000, ctrl_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == DMM_OFS_RPT) begin
        rpt_q <= DMM_RPT_W'(merge({24'h000000, rpt_q}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ****************************************
  // issue and single-instruction repeat
  // ****************************************
  assign inst_ready_o = (state_q == DMM_ST_IDLE);
  assign accept       = inst_valid_i && inst_ready_o && decode_ok(inst_word_i);
  assign issue        = accept || (state_q == DMM_ST_RPT);
  assign issue_word   = (state_q == DMM_ST_RPT) ? held_q : inst_word_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= DMM_ST_IDLE;
      rpt_left_q <= DMM_RPT_RST;
      held_q     <= 32'h00000000;
    end else begin
      case (state_q)
        DMM_ST_IDLE: begin
          if (accept && rpt_q != DMM_RPT_RST) begin
            state_q    <= DMM_ST_RPT;
            rpt_left_q <= rpt_q;
            held_q     <= inst_word_i;
          end
        end
        DMM_ST_RPT: begin
          rpt_left_q <= rpt_left_q - 8'h01;
          if (rpt_left_q == 8'h01) begin
            state_q <= DMM_ST_IDLE;
          end
        end
        default: state_q <= DMM_ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // pointers and operand addresses
  // ****************************************
  // post-modify beats a same-cycle bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cptr_q  <= DMM_PTR_RST;
      aptr3_q <= DMM_PTR_RST;
    end else begin
      if (issue) begin
        cptr_q  <= ptr_next(cptr_q, issue_word[DMM_F_CM_HI:DMM_F_CM_LO]);
        aptr3_q <= ptr_next(aptr3_q, issue_word[DMM_F_XM_HI:DMM_F_XM_LO]);
      end else if (wb_wr) begin
        if (wb_adr_i == DMM_OFS_CPTR) begin
          cptr_q <= 16'(merge({16'h0000, cptr_q}, wb_dat_i, wb_sel_i));
        end
        if (wb_adr_i == DMM_OFS_APTR3) begin
          aptr3_q <= 16'(merge({16'h0000, aptr3_q}, wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      s1_word_q  <= 32'h00000000;
      xa_q       <= DMM_PTR_RST;
      ca_q       <= DMM_PTR_RST;
      s2_valid_q <= 1'b0;
      s2_word_q  <= 32'h00000000;
      done_q     <= 1'b0;
    end else begin
      s1_valid_q <= issue;
      if (issue) begin
        s1_word_q <= issue_word;
        xa_q      <= aptr3_q;
        ca_q      <= cptr_q;
      end
      s2_valid_q <= s1_valid_q;
      s2_word_q  <= s1_word_q;
      done_q     <= s2_valid_q;
    end
  end

  assign rd_stb_o           = s1_valid_q;
  assign data_addr_hi_o     = xa_q;
  assign data_addr_lo_o     = {xa_q[15:1], ~xa_q[0]};
  assign coef_addr_bus_hi_o = ca_q;
  assign coef_addr_bus_lo_o = {ca_q[15:1], ~ca_q[0]};

  // ****************************************
  // dual datapath
  // ****************************************
  assign sub_idx  = s2_word_q[DMM_F_SUB_HI:DMM_F_SUB_LO];
  assign add_idx  = s2_word_q[DMM_F_ADD_HI:DMM_F_ADD_LO];
  assign wide_eff = ctrl_q[DMM_CTRL_WIDE] || s2_word_q[DMM_F_WIDE];
  assign add_src  = (s2_word_q[DMM_F_NIB_HI:DMM_F_NIB_LO] == DMM_NIB_SHIFT) ?
                    {{16{acc_q[add_idx][39]}}, acc_q[add_idx][39:16]} : acc_q[add_idx];

  assign prod_hi = mul_lane(ext17(long_read_bus_hi_i, s2_word_q[DMM_F_UNS_D]),
                            ext17(coef_bus_hi_i, s2_word_q[DMM_F_UNS_C]),
                            ctrl_q[DMM_CTRL_FRAC], ctrl_q[DMM_CTRL_MUL_SAT_MODE]);
  assign prod_lo = mul_lane(ext17(data_read_bus_i, s2_word_q[DMM_F_UNS_D]),
                            ext17(coef_bus_lo_i, s2_word_q[DMM_F_UNS_C]),
                            ctrl_q[DMM_CTRL_FRAC], ctrl_q[DMM_CTRL_MUL_SAT_MODE]);

  // both lanes read accumulators from before this edge
  assign add_res = acc_lane(add_src, prod_hi, 1'b0, s2_word_q[DMM_F_RND],
                            ctrl_q[DMM_CTRL_RDM], wide_eff, ctrl_q[DMM_CTRL_SAT]);
  assign sub_res = acc_lane(acc_q[sub_idx], prod_lo, 1'b1, s2_word_q[DMM_F_RND],
                            ctrl_q[DMM_CTRL_RDM], wide_eff, ctrl_q[DMM_CTRL_SAT]);

  always_comb begin
    ovf_set = '0;
    ovf_clr = '0;
    if (s2_valid_q) begin
      ovf_set[add_idx] = add_res[40];
      if (sub_res[40]) begin
        ovf_set[sub_idx] = 1'b1;
      end
    end
    if (wb_wr && wb_adr_i == DMM_OFS_STATUS && wb_sel_i[0]) begin
      ovf_clr = wb_dat_i[DMM_NACC-1:0];
    end
  end

  // ****************************************
  // accumulators and flags
  // ****************************************
  // same destination on both lanes: upper result kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DMM_NACC; i++) begin
        acc_q[i] <= 40'h0000000000;
      end
    end else begin
      for (int i = 0; i < DMM_NACC; i++) begin
        if (s2_valid_q && add_idx == i[1:0]) begin
          acc_q[i] <= add_res[39:0];
        end else if (s2_valid_q && sub_idx == i[1:0]) begin
          acc_q[i] <= sub_res[39:0];
        end else if (wb_wr && acc_sel && acc_idx == i[1:0]) begin
          if (wb_adr_i[DMM_ACC_HALF]) begin
            acc_q[i][39:32] <= wb_sel_i[0] ? wb_dat_i[7:0] : acc_q[i][39:32];
          end else begin
            acc_q[i][31:0] <= merge(acc_q[i][31:0], wb_dat_i, wb_sel_i);
          end
        end
      end
    end
  end

  // sticky flags: set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q <= '0;
      bad_q <= 1'b0;
    end else begin
      ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
      bad_q <= (bad_q && !(wb_wr && wb_adr_i == DMM_OFS_STATUS && wb_sel_i[1] && wb_dat_i[DMM_ST_BAD]))
               || (inst_valid_i && inst_ready_o && !decode_ok(inst_word_i));
    end
  end

  assign busy_o         = (state_q != DMM_ST_IDLE) || s1_valid_q || s2_valid_q;
  assign done_o         = done_q;
  assign acc_ovf_flag_o = ovf_q;

endmodule : dmm_core

// ===== tb/dmm_core_props.sv
// checker: bus, issue and result timing
// assumes one clock, bound onto every dmm_core
`timescale 1ns/10ps
module dmm_core_props
  import dmm_pkg::*;
(
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // bus and issue
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic                inst_valid_i,
  input wire logic [31:0]         inst_word_i,
  input wire logic                inst_ready_o,
  // operand side and status
  input wire logic                rd_stb_o,
  input wire logic [DMM_ADR_W-1:0] data_addr_hi_o,
  input wire logic [DMM_ADR_W-1:0] data_addr_lo_o,
  input wire logic [DMM_ADR_W-1:0] coef_addr_bus_hi_o,
  input wire logic [DMM_ADR_W-1:0] coef_addr_bus_lo_o,
  input wire logic                busy_o,
  input wire logic                done_o,
  input wire logic [DMM_NACC-1:0] acc_ovf_flag_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ok_w;
  assign ok_w = inst_valid_i && inst_ready_o && inst_word_i[31:24] == DMM_OPC_FIRST &&
    inst_word_i[11:10] == DMM_FIX_BITS && inst_word_i[15:12] inside {DMM_NIB_SHIFT, DMM_NIB_PLAIN};
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dlo; rd_stb_o |-> data_addr_lo_o == {data_addr_hi_o[15:1], !data_addr_hi_o[0]}; endproperty
  property p_clo; rd_stb_o |-> coef_addr_bus_lo_o == {coef_addr_bus_hi_o[15:1], !coef_addr_bus_hi_o[0]}; endproperty
  property p_issue; ok_w |=> rd_stb_o; endproperty
  property p_done; rd_stb_o |-> ##2 done_o; endproperty
  // flags rise only with a result
  property p_flag; |(acc_ovf_flag_o & ~$past(acc_ovf_flag_o)) |-> done_o; endproperty
  property p_busy; !inst_ready_o |-> busy_o; endproperty
  property p_hold; !rd_stb_o |-> $stable(coef_addr_bus_hi_o) && $stable(data_addr_hi_o); endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  a_ack_once: assert property (p_ack_once) else $error("long ack");
  a_dlo: assert property (p_dlo) else $error("data partner");
  a_clo: assert property (p_clo) else $error("coef partner");
  a_issue: assert property (p_issue) else $error("no issue");
  a_done: assert property (p_done) else $error("late result");
  a_flag: assert property (p_flag) else $error("stray flag");
  a_busy: assert property (p_busy) else $error("busy low");
  a_hold: assert property (p_hold) else $error("address moved");
  c_done: cover property (done_o);
  c_ovf: cover property (|acc_ovf_flag_o);
  c_rpt: cover property (!inst_ready_o);
endmodule : dmm_core_props

bind dmm_core dmm_core_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .inst_valid_i,
  .inst_word_i, .inst_ready_o, .rd_stb_o, .data_addr_hi_o, .data_addr_lo_o, .coef_addr_bus_hi_o,
  .coef_addr_bus_lo_o, .busy_o, .done_o, .acc_ovf_flag_o);

// ===== tb/dmm_opmem.sv
// operand memory model: one-cycle read latency
// assumes contents loaded by the bench
`timescale 1ns/10ps
module dmm_opmem (
  // clock and request
  input  wire logic        clk_i,
  input  wire logic        rd_stb_i,
  input  wire logic [15:0] dhi_adr_i,
  input  wire logic [15:0] dlo_adr_i,
  input  wire logic [15:0] chi_adr_i,
  input  wire logic [15:0] clo_adr_i,
  // read data
  output logic      [15:0] dhi_o,
  output logic      [15:0] dlo_o,
  output logic      [15:0] chi_o,
  output logic      [15:0] clo_o
);
  // ****************************************
  // storage and read port
  // ****************************************
  logic [15:0] mem [0:65535];
  int          n_rd = 0;
  initial {dhi_o, dlo_o, chi_o, clo_o} = 64'h0;
  // outside the read slot the buses toggle so stale data never passes
  always @(posedge clk_i) begin
    if (rd_stb_i) begin // data and coefficient words latched together
      {dhi_o, dlo_o, chi_o, clo_o} <= {mem[dhi_adr_i], mem[dlo_adr_i], mem[chi_adr_i], mem[clo_adr_i]};
      n_rd <= n_rd + 1;
    end else begin
      {dhi_o, dlo_o, chi_o, clo_o} <= ~{dhi_o, dlo_o, chi_o, clo_o};
    end
  end
endmodule : dmm_opmem

// ===== tb/tb_dmm_core.sv
// bench for dmm_core: registers, issue, results
// assumes dmm_opmem stands in for operand memory
`timescale 1ns/10ps
module tb_dmm_core import dmm_pkg::*;;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, inst_valid_i = 0;
  logic        wb_ack_o, inst_ready_o, rd_stb_o, busy_o, done_o;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0, acc_ovf_flag_o;
  logic [31:0] wb_dat_i = 32'h0, inst_word_i = 32'h0, wb_dat_o;
  logic [15:0] data_addr_hi_o, data_addr_lo_o, coef_addr_bus_hi_o, coef_addr_bus_lo_o;
  logic [15:0] long_read_bus_hi_i, data_read_bus_i, coef_bus_hi_i, coef_bus_lo_i;
  int          err_total = 0, checked = 0;
  dmm_core DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .inst_valid_i, .inst_word_i, .inst_ready_o, .rd_stb_o, .data_addr_hi_o,
    .data_addr_lo_o, .coef_addr_bus_hi_o, .coef_addr_bus_lo_o, .long_read_bus_hi_i, .data_read_bus_i,
    .coef_bus_hi_i, .coef_bus_lo_i, .busy_o, .done_o, .acc_ovf_flag_o);
  dmm_opmem u_mem (.clk_i, .rd_stb_i(rd_stb_o), .dhi_adr_i(data_addr_hi_o), .dlo_adr_i(data_addr_lo_o),
    .chi_adr_i(coef_addr_bus_hi_o), .clo_adr_i(coef_addr_bus_lo_o), .dhi_o(long_read_bus_hi_i),
    .dlo_o(data_read_bus_i), .chi_o(coef_bus_hi_i), .clo_o(coef_bus_lo_i));
  initial forever #5 clk_i = ~clk_i;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) err_total++;
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [39:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, {8'h00, q}, exp);
  endtask : rd
  task automatic wacc(input int i, input logic [39:0] v);
    wr(8'h20 + 8'(8 * i), v[31:0]);
    wr(8'h24 + 8'(8 * i), {24'h0, v[39:32]});
  endtask : wacc
  task automatic racc(input int i, input logic [39:0] exp);
    logic [31:0] lo, hi;
    wb(1'b0, 8'h20 + 8'(8 * i), 32'h0, lo);
    wb(1'b0, 8'h24 + 8'(8 * i), 32'h0, hi);
    chk("acc", {hi[7:0], lo}, exp);
  endtask : racc
  function automatic logic [31:0] iw(logic [3:0] nib, logic [1:0] xm, cm, sb, ad, logic [3:0] opt);
    return {DMM_OPC_FIRST, 6'h00, xm, nib, DMM_FIX_BITS, cm, sb, ad, opt};
  endfunction : iw
  task automatic issue(input logic [31:0] w, input bit wait_done);
    int n = 0;
    @(posedge clk_i);
    {inst_valid_i, inst_word_i} <= {1'b1, w};
    @(posedge clk_i);
    inst_valid_i <= 1'b0;
    while (wait_done && done_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (wait_done && done_o !== 1'b1) err_total++;
    repeat (3) @(posedge clk_i);
  endtask : issue
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd("ctrl", DMM_OFS_CTRL, 40'h0);
    rd("cptr", DMM_OFS_CPTR, 40'h0);
    rd("rpt", DMM_OFS_RPT, 40'h0);
    wr(8'hFC, 32'hFFFFFFFF);
    rd("unmapped", 8'hFC, 40'h0);
  endtask : t_regs
  task automatic t_shift();
    {u_mem.mem[16'h10FF], u_mem.mem[16'h10FE]} = {16'hFE00, 16'hFE00};
    {u_mem.mem[16'h2000], u_mem.mem[16'h2001]} = {16'h8000, 16'h4000};
    wr(DMM_OFS_APTR3, 32'h10FF);
    wr(DMM_OFS_CPTR, 32'h2000);
    wacc(0, 40'h0000008000);
    wacc(1, 40'h0008000000);
    issue(iw(DMM_NIB_SHIFT, 2'h2, 2'h1, 2'h0, 2'h1, 4'hC), 1'b1);
    racc(1, 40'h007F000800);
    racc(0, 40'hFFC0808000);
    rd("cptr", DMM_OFS_CPTR, 40'h2002);
    rd("aptr3", DMM_OFS_APTR3, 40'h10FD);
  endtask : t_shift
  task automatic t_frac();
    {u_mem.mem[16'h30], u_mem.mem[16'h31], u_mem.mem[16'h50], u_mem.mem[16'h51]} = 64'h8000800080000002;
    wr(DMM_OFS_CTRL, 32'h3);
    wr(DMM_OFS_APTR3, 32'h30);
    wr(DMM_OFS_CPTR, 32'h50);
    wacc(0, 40'h0);
    wacc(1, 40'h0);
    issue(iw(DMM_NIB_PLAIN, 2'h0, 2'h0, 2'h1, 2'h0, 4'h0), 1'b1);
    racc(0, 40'h007FFFFFFF);
    racc(1, 40'h0000020000);
  endtask : t_frac
  task automatic t_ovf();
    {u_mem.mem[16'h20], u_mem.mem[16'h21]} = {16'h0001, 16'hFFFF};
    for (int a = 16'h40; a < 16'h44; a++) u_mem.mem[a] = 16'h0001;
    wr(DMM_OFS_CTRL, 32'h14);
    wr(DMM_OFS_APTR3, 32'h20);
    wr(DMM_OFS_CPTR, 32'h40);
    wacc(2, 40'h007FFFFFFF);
    wacc(3, 40'h0000007FFF);
    issue(iw(DMM_NIB_PLAIN, 2'h0, 2'h1, 2'h3, 2'h2, 4'h1), 1'b1);
    racc(2, 40'h007FFFFFFF);
    racc(3, 40'h0000000000);
    chk("flags", {36'h0, acc_ovf_flag_o}, 40'h4);
    wr(DMM_OFS_STATUS, 32'hF);
    chk("flags", {36'h0, acc_ovf_flag_o}, 40'h0);
  endtask : t_ovf
  task automatic t_rpt();
    int n0;
    wr(DMM_OFS_CPTR, 32'h40);
    wr(DMM_OFS_RPT, 32'h1);
    n0 = u_mem.n_rd;
    issue(iw(DMM_NIB_PLAIN, 2'h0, 2'h1, 2'h3, 2'h2, 4'h2), 1'b1);
    chk("issues", 40'(u_mem.n_rd - n0), 40'h2);
    racc(2, 40'h0080000001);
    racc(3, 40'h0000000002);
    rd("cptr", DMM_OFS_CPTR, 40'h44);
    rd("ctrl", DMM_OFS_CTRL, 40'h14);
    chk("flags", {36'h0, acc_ovf_flag_o}, 40'h0);
  endtask : t_rpt
  task automatic t_bad();
    wr(DMM_OFS_RPT, 32'h0);
    issue(32'h00006400, 1'b0);
    rd("status", DMM_OFS_STATUS, 40'h100);
  endtask : t_bad
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_shift();
    t_frac();
    t_ovf();
    t_rpt();
    t_bad();
    print_verdict();
  end
  // run needs under a thousand cycles
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : tb_dmm_core
